// >>> hdl/xio_map.vh
// constants for the expansion module i/o port
// assumes inclusion by bare name from the lane and port design files
`ifndef XIO_MAP_VH
`define XIO_MAP_VH
`define XIO_CLK_PERIOD_NS   25
`define XIO_WAIT_FIX_NS     75
`define XIO_RD_VALID_NS     250
`define XIO_WR_PULSE_NS     300
`define XIO_DMA_TERMINATE_PULSE_NS   500
`define XIO_WAIT_FIX_CYC    (`XIO_WAIT_FIX_NS / `XIO_CLK_PERIOD_NS)
`define XIO_RD_VALID_CYC    (`XIO_RD_VALID_NS / `XIO_CLK_PERIOD_NS)
`define XIO_WR_PULSE_CYC    ((`XIO_WR_PULSE_NS + `XIO_CLK_PERIOD_NS - 1) / `XIO_CLK_PERIOD_NS)
`define XIO_DMA_TERMINATE_CYC        ((`XIO_DMA_TERMINATE_PULSE_NS + `XIO_CLK_PERIOD_NS - 1) / `XIO_CLK_PERIOD_NS)
`define XIO_PORT_INT0_CLR   3'h6
`define XIO_PORT_INT1_CLR   3'h7
`define XIO_PORT_DMA        3'h5
`define XIO_SYNC_STAGES     2
`endif

// >>> hdl/xio_sync.v
// two-flop level synchroniser, one per bit
// assumes inputs asynchronous to ref_clk
`timescale 1ns/10ps
module xio_sync #(
   parameter WIDTH = 1,
   parameter [WIDTH-1:0] INIT = {WIDTH{1'b0}}
) (
   input  wire             ref_clk, // clock
   input  wire             rst,     // sync reset
   input  wire [WIDTH-1:0] async_in,// raw input
   output wire [WIDTH-1:0] sync_out // synchronised
);
   reg [WIDTH-1:0] meta;
   reg [WIDTH-1:0] stable;
   // first stage only feeds second stage
   always @(posedge ref_clk) begin
      if (rst) begin
         meta   <= INIT;
         stable <= INIT;
      end else begin
         meta   <= async_in;
         stable <= meta;
      end
   end
   assign sync_out = stable;
endmodule

// >>> hdl/xio_lane.v
// one 8-bit data lane: read mux source and write capture
// assumes strobes already synchronised and qualified
`timescale 1ns/10ps
`include "xio_map.vh"
module xio_lane #(
   parameter NPORT = 8
) (
   input  wire       ref_clk,  // clock
   input  wire       rst,      // sync reset
   input  wire       lane_sel, // lane enabled
   input  wire [2:0] port,     // port index
   input  wire       wr_pulse, // capture write
   input  wire [7:0] wr_data,  // bus byte in
   input  wire [7:0] rd_in,    // user read byte
   output reg  [7:0] rd_data,  // byte for bus
   output reg  [7:0] wr_out,   // last written byte
   output reg  [2:0] wr_port,  // written port
   output reg        wr_valid  // one-cycle write pulse
);
   always @(posedge ref_clk) begin
      if (rst) begin
         rd_data  <= 8'h00;
         wr_out   <= 8'h00;
         wr_port  <= 3'h0;
         wr_valid <= 1'b0;
      end else begin
         rd_data  <= rd_in;
         wr_valid <= wr_pulse & lane_sel;
         if (wr_pulse & lane_sel) begin
            wr_out  <= wr_data;
            wr_port <= port;
         end
      end
   end
endmodule

// >>> hdl/xio_port.v
// expansion module i/o port, module side
// Summary of operation
// - active-low select qualifies strobes, picks port
// - wait corrected within 75 ns
// - low, high, both selects pick lanes
// - word is both byte lanes together
// - data bus active high, bit0 lsb
// - interrupts are active-high levels
// - interrupt held until clear port accessed
// - read data valid under 250 ns
// - extended read holds wait until data
// - wait from select and address only
// - extended write releases wait after pulse
// - dma request starts dma cycle
// - grant replaces select and address
// - drop request to end dma burst
// - reset gives known state
// - module clock asynchronous to interface
// - terminate output ends dma activity
// assumes host strobes, selects, grant asynchronous to ref_clk;
// user logic supplies read bytes and consumes write pulses;
// host holds write data only briefly after the strobe rises;
// dma transfers always address one fixed internal port
`timescale 1ns/10ps
`include "xio_map.vh"
module xio_port #(
   parameter WIDE      = 1,  // 1: 16-bit module, 0: 8-bit
   parameter SLOW_RD   = 1,  // 1: extended read with wait
   parameter SLOW_WR   = 1,  // 1: extended write with wait
   parameter RD_CYC    = 4,  // internal read latency in cycles
   parameter DMA_PORT  = `XIO_PORT_DMA
) (
   input  wire        ref_clk,            // 40 MHz clock
   input  wire        rst,                // host reset, sync high
   input  wire [2:0]  port_addr,          // port address
   input  wire        low_byte_select_n,  // low lane select
   input  wire        high_byte_select_n, // high lane select
   input  wire        io_read_strobe_n,   // read strobe
   input  wire        io_write_strobe_n,  // write strobe
   input  wire        dma_grant_n,        // dma acknowledge
   input  wire [15:0] module_data_in,     // bus level in
   output wire [15:0] module_data_out,    // bus drive value
   output wire [15:0] module_data_oe,     // bus drive enable
   output wire        wait_request_n,     // wait, low active
   output reg  [1:0]  interrupt_request,  // interrupt levels
   output reg         dma_request,        // dma request
   output reg         dma_terminate,      // dma terminate
   input  wire [15:0] user_rd_data,       // read data from user
   output wire [15:0] user_wr_data,       // captured write data
   output wire [2:0]  user_port,          // port of last low-lane write
   output wire [1:0]  user_wr_valid,      // lane write pulses
   input  wire [1:0]  user_irq_set,       // interrupt events
   input  wire        user_dma_req,       // want dma transfer
   input  wire        user_dma_last,      // current is last
   input  wire        user_dma_abort      // terminate dma
);
   // ------------------------------------------------------------
   // synchronisers
   // ------------------------------------------------------------
   wire [6:0] raw_in = {dma_grant_n, io_write_strobe_n, io_read_strobe_n,
                        high_byte_select_n, low_byte_select_n, 2'b00};
   wire [6:0] s_in;
   wire [2:0] s_addr;
   // ref_clk unrelated to host timing
   // two flops per input cost two clocks of latency
   // sync control inputs
   xio_sync #(.WIDTH(7), .INIT(7'h7C)) u_sync_ctl (
      .ref_clk  (ref_clk),
      .rst      (rst),
      .async_in (raw_in),
      .sync_out (s_in)
   );
   xio_sync #(.WIDTH(3), .INIT(3'h0)) u_sync_adr (
      .ref_clk  (ref_clk),
      .rst      (rst),
      .async_in (port_addr),
      .sync_out (s_addr)
   );
   wire lo_n  = s_in[2];
   wire hi_n  = s_in[3];
   wire rd_n  = s_in[4];
   wire wr_n  = s_in[5];
   wire dak_n = s_in[6];

   // ------------------------------------------------------------
   // timing constants
   // ------------------------------------------------------------
   // integer form keeps compares and loads explicit about width
   localparam integer WR_CYC   = `XIO_WR_PULSE_CYC;
   localparam integer DMA_TERMINATE_CYC = `XIO_DMA_TERMINATE_CYC;

   // ------------------------------------------------------------
   // qualification
   // ------------------------------------------------------------
   // grant overrides select and address
   wire       in_dma   = ~dak_n;
   wire       lane_lo  = in_dma | ~lo_n;
   // an 8-bit build never enables the high lane
   wire       lane_hi  = (WIDE != 0) & (in_dma ? 1'b1 : ~hi_n);
   wire       selected = lane_lo | lane_hi;
   wire [2:0] port     = in_dma ? DMA_PORT : s_addr;
   wire       rd_act   = selected & ~rd_n;
   wire       wr_act   = selected & ~wr_n;

   reg rd_q;
   reg wr_q;
   reg [7:0] cnt;
   reg wait_busy;
   reg done;
   wire rd_rise = rd_act & ~rd_q;
   wire wr_rise = wr_act & ~wr_q;
   wire wr_fall = ~wr_act & wr_q;

   // ------------------------------------------------------------
   // wait and data timing
   // ------------------------------------------------------------
   // wait only from select and address; strobes only end it
   // select drop clears wait in two clocks, under 75 ns
   // read wait held until data valid
   // write wait held for pulse time
   // done keeps wait off until select drops, so a long strobe never re-arms it
   wire need_wait = (rd_act ? (SLOW_RD != 0) : (SLOW_WR != 0));
   assign wait_request_n = ~(selected & ~done & wait_busy);

   always @(posedge ref_clk) begin
      if (rst) begin
         rd_q      <= 1'b0;
         wr_q      <= 1'b0;
         cnt       <= 8'h00;
         wait_busy <= 1'b0;
         done      <= 1'b0;
      end else begin
         rd_q <= rd_act;
         wr_q <= wr_act;
         if (!selected) begin
            wait_busy <= 1'b0;
            done      <= 1'b0;
            cnt       <= 8'h00;
         end else if (!done) begin
            wait_busy <= 1'b1;
            if (rd_act | wr_act) begin
               cnt <= cnt + 8'h01;
               if ((rd_act && cnt >= RD_CYC[7:0]) ||
                   (wr_act && cnt >= WR_CYC[7:0]) || !need_wait) begin
                  done <= 1'b1;
               end
            end
         end
      end
   end

   // ------------------------------------------------------------
   // write data capture
   // ------------------------------------------------------------
   // bus data runs through the same two stages as the strobe, so
   // the copy kept is the last one taken while the strobe read low;
   // sampling the live bus at the synchronised edge would be too late
   reg [15:0] din_meta;
   reg [15:0] din_stable;
   reg [15:0] din_hold;
   always @(posedge ref_clk) begin
      if (rst) begin
         din_meta   <= 16'h0000;
         din_stable <= 16'h0000;
         din_hold   <= 16'h0000;
      end else begin
         din_meta   <= module_data_in;
         din_stable <= din_meta;
         if (wr_act) begin
            din_hold <= din_stable;
         end
      end
   end

   // ------------------------------------------------------------
   // data lanes
   // ------------------------------------------------------------
   wire [7:0] rd_lo;
   wire [7:0] rd_hi;
   // write bytes come from the held copy, not the live bus
   wire wr_pulse = wr_fall;
   // word moves on both lanes at once
   xio_lane u_lane_lo (
      .ref_clk  (ref_clk),
      .rst      (rst),
      .lane_sel (lane_lo),
      .port     (port),
      .wr_pulse (wr_pulse),
      .wr_data  (din_hold[7:0]),
      .rd_in    (user_rd_data[7:0]),
      .rd_data  (rd_lo),
      .wr_out   (user_wr_data[7:0]),
      .wr_port  (user_port),
      .wr_valid (user_wr_valid[0])
   );
   xio_lane u_lane_hi (
      .ref_clk  (ref_clk),
      .rst      (rst),
      .lane_sel (lane_hi),
      .port     (port),
      .wr_pulse (wr_pulse),
      .wr_data  (din_hold[15:8]),
      .rd_in    (user_rd_data[15:8]),
      .rd_data  (rd_hi),
      .wr_out   (user_wr_data[15:8]),
      .wr_port  (),
      .wr_valid (user_wr_valid[1])
   );
   // data latched each clock, valid within sync delay
   // drive only during qualified read
   // bus released three clocks after the strobe rises
   reg oe_lo;
   reg oe_hi;
   always @(posedge ref_clk) begin
      if (rst) begin
         oe_lo <= 1'b0;
         oe_hi <= 1'b0;
      end else begin
         oe_lo <= rd_act & lane_lo;
         oe_hi <= rd_act & lane_hi;
      end
   end
   assign module_data_out = {rd_hi, rd_lo};
   assign module_data_oe  = {{8{oe_hi}}, {8{oe_lo}}};

   // ------------------------------------------------------------
   // interrupts
   // ------------------------------------------------------------
   // active-high levels
   // clear on access to clear port; set wins
   // port match, shared by both clear bits
   function hits_port;
      input [2:0] p;
      input [2:0] want;
      begin
         hits_port = (p == want);
      end
   endfunction
   wire acc = rd_rise | wr_rise;
   wire [1:0] clr = {acc & ~in_dma & hits_port(port, `XIO_PORT_INT1_CLR),
                     acc & ~in_dma & hits_port(port, `XIO_PORT_INT0_CLR)};
   always @(posedge ref_clk) begin
      if (rst) begin
         interrupt_request <= 2'b00;
      end else begin
         interrupt_request <= user_irq_set | (interrupt_request & ~clr);
      end
   end

   // ------------------------------------------------------------
   // dma
   // ------------------------------------------------------------
   reg [4:0] tcnt;
   reg       last_seen;
   always @(posedge ref_clk) begin
      if (rst) begin
         dma_request   <= 1'b0;
         dma_terminate <= 1'b0;
         tcnt          <= 5'h00;
         last_seen     <= 1'b0;
      end else begin
         // drop request during final transfer
         // grant always addresses the dma port, on both lanes only in a 16-bit build
         if (in_dma & (rd_rise | wr_rise)) begin
            if (user_dma_last) begin
               last_seen   <= 1'b1;
               dma_request <= 1'b0;
            end
         end else if (~in_dma) begin
            // an ended burst stays down until the user withdraws its request
            if (!user_dma_req) begin
               last_seen <= 1'b0;
            end
            dma_request <= user_dma_req & ~last_seen;
         end
         // terminate pulse at least 500 ns
         // a fresh abort restarts the count
         if (user_dma_abort) begin
            dma_terminate <= 1'b1;
            tcnt          <= DMA_TERMINATE_CYC[4:0];
         end else if (tcnt != 5'h00) begin
            tcnt <= tcnt - 5'h01;
         end else begin
            dma_terminate <= 1'b0;
         end
      end
   end
endmodule

// >>> tb/xio_port_properties.sv
// pin-level assertions for the module i/o port
// assumes a bind onto xio_port built with WIDE=1
`timescale 1ns/10ps
module xio_port_chk (
   input logic        ref_clk,            // clock
   input logic        rst,                // sync reset
   input logic        low_byte_select_n,  // low select
   input logic        high_byte_select_n, // high select
   input logic        io_read_strobe_n,   // read strobe
   input logic        io_write_strobe_n,  // write strobe
   input logic        dma_grant_n,        // dma grant
   input logic [15:0] module_data_oe,     // drive enable
   input logic        wait_request_n,     // wait
   input logic [1:0]  interrupt_request,  // irq levels
   input logic        dma_request,        // dma request
   input logic        dma_terminate,      // terminate
   input logic [1:0]  user_irq_set,       // irq events
   input logic        user_dma_last       // last transfer
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   logic [4:0] age;
   wire        no_sel = low_byte_select_n & high_byte_select_n & dma_grant_n;
   // cycles since a strobe was last low
   always_ff @(posedge ref_clk) begin
      if (rst || !io_read_strobe_n || !io_write_strobe_n) begin
         age <= 5'h00;
      end else begin
         age <= age + {4'h0, age != 5'h1F};
      end
   end
   sequence s_word_rd;
      (!low_byte_select_n && !high_byte_select_n && !io_read_strobe_n) [*4];
   endsequence
   sequence s_grant_rd;
      (!dma_grant_n && !io_read_strobe_n) [*4];
   endsequence
   a_reset_state: assert property ($fell(rst) |-> module_data_oe == 16'h0000 && wait_request_n
      && interrupt_request == 2'h0 && !dma_request && !dma_terminate) else $error("not idle after reset");
   a_idle_float: assert property (io_read_strobe_n [*5] |-> module_data_oe == 16'h0000)
      else $error("bus driven without read");
   a_wait_from_sel: assert property (no_sel [*5] |-> wait_request_n)
      else $error("wait held without select");
   a_read_in_time: assert property ($fell(io_read_strobe_n) && !low_byte_select_n |-> ##[1:9] module_data_oe[0])
      else $error("read data late");
   a_word_lanes: assert property (s_word_rd |-> module_data_oe == 16'hFFFF)
      else $error("word read not on both lanes");
   a_grant_lanes: assert property (s_grant_rd |-> module_data_oe == 16'hFFFF)
      else $error("grant read not driven");
   a_irq_raise: assert property (user_irq_set[0] |=> interrupt_request[0])
      else $error("interrupt not raised");
   a_irq_clear: assert property ($fell(interrupt_request[0]) |-> age < 5'h05)
      else $error("interrupt dropped without access");
   a_dreq_drop: assert property (user_dma_last && !dma_grant_n && !io_read_strobe_n |-> ##[1:6] !dma_request)
      else $error("dma request not dropped");
endmodule
bind xio_port xio_port_chk u_chk (.*);

// >>> tb/xio_host.sv
// host board model: cpu and dma controller bus cycles
// assumes the bench calls cycle() and the port drives on oe
`timescale 1ns/10ps
module xio_host (
   input  logic        ref_clk,            // clock
   output logic [2:0]  port_addr,          // port address
   output logic        low_byte_select_n,  // low select
   output logic        high_byte_select_n, // high select
   output logic        io_read_strobe_n,   // read strobe
   output logic        io_write_strobe_n,  // write strobe
   output logic        dma_grant_n,        // dma grant
   output logic [15:0] module_data_in,     // resolved bus
   input  logic [15:0] module_data_out,    // module drive
   input  logic [15:0] module_data_oe,     // module enable
   input  logic        wait_request_n      // wait
);
   logic [15:0] hd = 16'h0000;
   logic [15:0] last = 16'h0000;
   logic        hen = 1'b0;
   initial begin
      {low_byte_select_n, high_byte_select_n, io_read_strobe_n, io_write_strobe_n, dma_grant_n} = 5'h1F;
      port_addr = 3'h0;
   end
   // undriven lines toggle, never hold
   assign module_data_in = (module_data_oe & module_data_out) | (~module_data_oe & (hen ? hd : ~last));
   always @(posedge ref_clk) last <= module_data_in;
   task automatic cycle(input logic wr, input logic [1:0] ln, input logic [2:0] a, input logic [15:0] d,
                        input logic dma, output logic [15:0] q);
      int n;
      @(posedge ref_clk);
      port_addr <= a;
      low_byte_select_n <= ~(ln[0] & ~dma);
      high_byte_select_n <= ~(ln[1] & ~dma);
      dma_grant_n <= ~dma;
      hd <= d;
      hen <= wr;
      @(posedge ref_clk);
      if (wr) io_write_strobe_n <= 1'b0;
      else io_read_strobe_n <= 1'b0;
      repeat (12) @(posedge ref_clk);
      n = 0;
      while (!wait_request_n && n < 200) begin
         @(posedge ref_clk);
         n++;
      end
      q = module_data_in;
      io_write_strobe_n <= 1'b1;
      io_read_strobe_n <= 1'b1;
      repeat (2) @(posedge ref_clk);
      {low_byte_select_n, high_byte_select_n, dma_grant_n, hen} <= 4'hE;
      port_addr <= ~a;
      repeat (4) @(posedge ref_clk);
   endtask
endmodule

// >>> tb/xio_port_test.sv
// self-checking bench for the module i/o port
// assumes xio_host as the host board
`timescale 1ns/10ps
`define XIO_CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin num_errors++; \
   $display("mismatch %s expected %h seen %h", nm, e, g); end end
module xio_port_test;
   logic        ref_clk = 1'b0;
   logic        rst = 1'b1;
   logic [2:0]  port_addr, user_port;
   logic        low_byte_select_n, high_byte_select_n, io_read_strobe_n, io_write_strobe_n, dma_grant_n;
   logic [15:0] module_data_in, module_data_out, module_data_oe, user_wr_data, q, got_d;
   logic        wait_request_n, dma_request, dma_terminate;
   logic [1:0]  interrupt_request, user_wr_valid, got_v;
   logic [15:0] user_rd_data = 16'hA5C3;
   logic [1:0]  user_irq_set = 2'h0;
   logic        user_dma_req = 1'b0;
   logic        user_dma_last = 1'b0;
   logic        user_dma_abort = 1'b0;
   int          num_errors = 0;
   int          checks_done = 0;
   always #12.5 ref_clk = ~ref_clk;
   xio_port dut (.*);
   xio_host u_host (.*);
   // write pulses are one cycle wide, keep them
   always @(posedge ref_clk) if (|user_wr_valid) {got_v, got_d} <= {user_wr_valid, user_wr_data};
   task automatic give_verdict;
      $display("checks %0d errors %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task automatic t_lanes;
      logic [15:0] m;
      for (int i = 1; i < 4; i++) begin
         m = {{8{i[1]}}, {8{i[0]}}};
         got_v <= 2'h0;
         u_host.cycle(1'b1, i[1:0], 3'h2, 16'h1234, 1'b0, q);
         `XIO_CHK("lanes", i[1:0], got_v)
         `XIO_CHK("wdata", 16'h1234 & m, got_d & m)
         `XIO_CHK("wport", 3'h2, user_port)
         u_host.cycle(1'b0, i[1:0], 3'h3, 16'h0000, 1'b0, q);
         `XIO_CHK("rdata", 16'hA5C3 & m, q & m)
      end
      got_v <= 2'h0;
      u_host.cycle(1'b1, 2'h0, 3'h2, 16'hFFFF, 1'b0, q);
      `XIO_CHK("unselected", 2'h0, got_v)
   endtask
   task automatic t_irq;
      @(posedge ref_clk) user_irq_set <= 2'h3;
      @(posedge ref_clk) user_irq_set <= 2'h0;
      u_host.cycle(1'b0, 2'h3, 3'h1, 16'h0000, 1'b0, q);
      `XIO_CHK("irq held", 2'h3, interrupt_request)
      u_host.cycle(1'b0, 2'h3, 3'h6, 16'h0000, 1'b0, q);
      `XIO_CHK("irq0 clr", 2'h2, interrupt_request)
      u_host.cycle(1'b1, 2'h3, 3'h7, 16'h0000, 1'b0, q);
      `XIO_CHK("irq1 clr", 2'h0, interrupt_request)
   endtask
   task automatic t_dma;
      @(posedge ref_clk) user_dma_req <= 1'b1;
      repeat (3) @(posedge ref_clk);
      `XIO_CHK("dreq", 1'b1, dma_request)
      u_host.cycle(1'b0, 2'h0, 3'h0, 16'h0000, 1'b1, q);
      `XIO_CHK("dma data", 16'hA5C3, q)
      `XIO_CHK("burst", 1'b1, dma_request)
      user_dma_last <= 1'b1;
      u_host.cycle(1'b0, 2'h0, 3'h0, 16'h0000, 1'b1, q);
      {user_dma_last, user_dma_req} <= 2'h0;
      `XIO_CHK("dreq end", 1'b0, dma_request)
      @(posedge ref_clk) user_dma_abort <= 1'b1;
      @(posedge ref_clk) user_dma_abort <= 1'b0;
      // terminate must last 500 ns, twenty clocks
      repeat (20) begin
         @(posedge ref_clk);
         `XIO_CHK("term", 1'b1, dma_terminate)
      end
      repeat (4) @(posedge ref_clk);
      `XIO_CHK("term end", 1'b0, dma_terminate)
   endtask
   initial begin
      repeat (5) @(posedge ref_clk);
      rst <= 1'b0;
      repeat (3) @(posedge ref_clk);
      `XIO_CHK("oe rst", 16'h0000, module_data_oe)
      `XIO_CHK("wait rst", 1'b1, wait_request_n)
      t_lanes;
      t_irq;
      t_dma;
      give_verdict;
   end
   initial begin
      repeat (8000) @(posedge ref_clk);
      num_errors++;
      give_verdict;
   end
endmodule
